/* core/igel_pkg.sv */
// constants for the isolated gate enable logic
// assumes one 40 MHz clock and a synchronous active-high reset
// Contract
// - standard mode: gate follows enable level
// - one-shot: each enable rise gives one pulse
// - next pulse only after enable returns low
// - one-shot allowed only in three-wire mode
// - high rail down: gate low, keep-off on
// - primary lost: gate low after timeout
// - high rail droop to threshold: gate low
// - wire mode latched at power-up until cycled
// - high or mid rail undervoltage: gate low
// - thermal fault: stop transfer, gate low
package igel_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int PRIMARY_TIMEOUT_US = 100;
    localparam int PRIMARY_TIMEOUT_CYC = PRIMARY_TIMEOUT_US * (CLK_HZ / 1_000_000);
    localparam int ONE_SHOT_NS = 1000;
    localparam int ONE_SHOT_CYC = (ONE_SHOT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int SYNC_STAGES = 2;
    // ------------------------------------------------------------
    // reset values and modes
    // ------------------------------------------------------------
    localparam logic GATE_RESET = 1'b0;
    localparam logic KEEP_OFF_RESET = 1'b1;
    localparam logic TIMED_OUT_RESET = 1'b1;
    localparam logic POWER_XFER_RESET = 1'b0;
    localparam logic THREE_WIRE_RESET = 1'b0;
    typedef enum logic [2:0] {
        IGEL_ST_OFF = 3'b001,
        IGEL_ST_PULSE = 3'b010,
        IGEL_ST_WAIT_LOW = 3'b100
    } igel_shot_t;
endpackage

/* core/igel_core.sv */
// gate drive decision logic for the isolated switch driver
// assumes supply-good and enable levels arrive asynchronously from pins
`timescale 1ns/1ps
module igel_core #(
    parameter int TIMEOUT_CYC = igel_pkg::PRIMARY_TIMEOUT_CYC,
    parameter int SHOT_CYC = igel_pkg::ONE_SHOT_CYC
) (
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic ENABLE_I,
    input wire logic PRIMARY_SUPPLY_GOOD_I,
    input wire logic SECONDARY_HIGH_RAIL_GOOD_I,
    input wire logic SECONDARY_MID_RAIL_GOOD_I,
    input wire logic THERMAL_FAULT_I,
    input wire logic THREE_WIRE_STRAP_I,
    input wire logic ONE_SHOT_VARIANT_I,
    output logic GATE_DRIVE_OUT_O,
    output logic KEEP_OFF_O,
    output logic POWER_TRANSFER_O,
    output logic THREE_WIRE_MODE_O
);
    import igel_pkg::*;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int NIN = 7;
    logic [NIN-1:0] raw;
    logic [NIN-1:0] sync1;
    logic [NIN-1:0] sync2;
    assign raw = {ONE_SHOT_VARIANT_I, THREE_WIRE_STRAP_I, THERMAL_FAULT_I,
                  SECONDARY_MID_RAIL_GOOD_I, SECONDARY_HIGH_RAIL_GOOD_I,
                  PRIMARY_SUPPLY_GOOD_I, ENABLE_I};

    // two flops per input, first stage read only by second
    genvar g;
    generate
        for (g = 0; g < NIN; g++) begin : gen_sync
            always_ff @(posedge CLK_I) begin
                if (RESET_I) begin
                    sync1[g] <= 1'b0;
                    sync2[g] <= 1'b0;
                end else begin
                    sync1[g] <= raw[g];
                    sync2[g] <= sync1[g];
                end
            end
        end
    endgenerate

    logic en_s, prim_ok, high_ok, mid_ok, therm, strap, variant;
    assign en_s = sync2[0];
    assign prim_ok = sync2[1];
    assign high_ok = sync2[2];
    assign mid_ok = sync2[3];
    assign therm = sync2[4];
    assign strap = sync2[5];
    assign variant = sync2[6];

    // ------------------------------------------------------------
    // mode latch at primary power-up
    // ------------------------------------------------------------
    logic prim_ok_d;
    logic prim_rise;
    logic mode_valid;
    logic three_wire;
    logic one_shot_en;
    logic timed_out;

    // delayed primary-good for the power-up edge
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            prim_ok_d <= 1'b0;
        end else begin
            prim_ok_d <= prim_ok;
        end
    end

    // resets low, so a primary already up at release still latches
    assign prim_rise = prim_ok & ~prim_ok_d;

    // mode caught on primary rising, dropped only after a full loss
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            mode_valid <= 1'b0;
            three_wire <= THREE_WIRE_RESET;
            one_shot_en <= 1'b0;
        end else if (!prim_ok && timed_out) begin
            mode_valid <= 1'b0;
        end else if (prim_rise && !mode_valid) begin
            mode_valid <= 1'b1;
            three_wire <= strap;
            one_shot_en <= strap & variant;
        end
    end

    // ------------------------------------------------------------
    // primary loss timeout
    // ------------------------------------------------------------
    localparam int TO_W = $clog2(TIMEOUT_CYC + 1);
    localparam logic [TO_W-1:0] TO_LAST = TO_W'(TIMEOUT_CYC - 1);
    logic [TO_W-1:0] to_cnt;

    // cycles counted while primary is absent, held at the last count
    always_ff @(posedge CLK_I) begin
        if (RESET_I || prim_ok) begin
            to_cnt <= '0;
        end else if (to_cnt != TO_LAST) begin
            to_cnt <= to_cnt + 1'b1;
        end
    end

    // flag starts expired, so the gate waits for a primary rise
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            timed_out <= TIMED_OUT_RESET;
        end else if (prim_ok) begin
            timed_out <= 1'b0;
        end else if (to_cnt == TO_LAST) begin
            timed_out <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // fault gating
    // ------------------------------------------------------------
    logic rails_ok;
    logic fault_free;
    logic drive_allowed;

    // either secondary rail low or droop forces gate low
    assign rails_ok = high_ok & mid_ok;
    // overtemperature blocks the drive whatever the primary state
    assign fault_free = rails_ok & ~therm;
    // primary loss blocks only once its timeout has run out
    assign drive_allowed = fault_free & ~timed_out & mode_valid;

    // ------------------------------------------------------------
    // one-shot sequencer
    // ------------------------------------------------------------
    localparam int SH_W = $clog2(SHOT_CYC + 1);
    localparam logic [SH_W-1:0] SH_LAST = SH_W'(SHOT_CYC - 1);
    igel_shot_t shot;
    logic [SH_W-1:0] shot_cnt;

    // one pulse per enable rise, rearm only after enable low
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            shot <= IGEL_ST_WAIT_LOW; // no false edge out of reset
        end else begin
            case (shot)
                IGEL_ST_OFF: begin
                    if (en_s && drive_allowed) begin
                        shot <= IGEL_ST_PULSE;
                    end else if (en_s) begin
                        shot <= IGEL_ST_WAIT_LOW; // rise in fault consumed
                    end
                end
                IGEL_ST_PULSE: begin
                    if (!drive_allowed || shot_cnt == SH_LAST) begin
                        shot <= IGEL_ST_WAIT_LOW;
                    end
                end
                IGEL_ST_WAIT_LOW: begin
                    if (!en_s) begin
                        shot <= IGEL_ST_OFF;
                    end
                end
                default: begin
                    shot <= IGEL_ST_WAIT_LOW;
                end
            endcase
        end
    end

    // pulse length counter, cleared outside the pulse
    always_ff @(posedge CLK_I) begin
        if (RESET_I || shot != IGEL_ST_PULSE) begin
            shot_cnt <= '0;
        end else if (shot_cnt != SH_LAST) begin
            shot_cnt <= shot_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic next_gate;
    always_comb begin
        if (!drive_allowed) begin
            next_gate = 1'b0;
        end else if (one_shot_en) begin
            next_gate = (shot == IGEL_ST_PULSE);
        end else begin
            next_gate = en_s;
        end
    end

    // registered gate drive
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            GATE_DRIVE_OUT_O <= GATE_RESET;
        end else begin
            GATE_DRIVE_OUT_O <= next_gate;
        end
    end

    // keep-off whenever the gate may not drive
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            KEEP_OFF_O <= KEEP_OFF_RESET;
        end else begin
            KEEP_OFF_O <= ~high_ok | ~drive_allowed;
        end
    end

    // power transfer stops on primary loss or overtemperature
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            POWER_TRANSFER_O <= POWER_XFER_RESET;
        end else begin
            POWER_TRANSFER_O <= prim_ok & ~therm;
        end
    end

    // latched wire mode shown to the outside
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            THREE_WIRE_MODE_O <= THREE_WIRE_RESET;
        end else begin
            THREE_WIRE_MODE_O <= three_wire;
        end
    end
endmodule

/* tb/igel_chk.sv */
// checker for the gate enable decision, bound to igel_core
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module igel_chk #(
    parameter int TIMEOUT_CYC = 8,
    parameter int SHOT_CYC = 3
) (
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic ENABLE_I,
    input wire logic PRIMARY_SUPPLY_GOOD_I,
    input wire logic SECONDARY_HIGH_RAIL_GOOD_I,
    input wire logic SECONDARY_MID_RAIL_GOOD_I,
    input wire logic THERMAL_FAULT_I,
    input wire logic THREE_WIRE_STRAP_I,
    input wire logic ONE_SHOT_VARIANT_I,
    input wire logic GATE_DRIVE_OUT_O,
    input wire logic KEEP_OFF_O,
    input wire logic POWER_TRANSFER_O,
    input wire logic THREE_WIRE_MODE_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RESET_I);
    logic shot, good;
    int low_cnt;
    // one-shot mode and all supplies healthy
    assign shot = THREE_WIRE_MODE_O && ONE_SHOT_VARIANT_I;
    assign good = PRIMARY_SUPPLY_GOOD_I && SECONDARY_HIGH_RAIL_GOOD_I
        && SECONDARY_MID_RAIL_GOOD_I && !THERMAL_FAULT_I;
    // cycles spent with the primary supply lost
    always_ff @(posedge CLK_I) begin
        if (RESET_I || PRIMARY_SUPPLY_GOOD_I) low_cnt <= 0;
        else if (low_cnt < 255) low_cnt <= low_cnt + 1;
    end
    std_follow_a: assert property (
        (ENABLE_I && good && !shot)[*8] |-> GATE_DRIVE_OUT_O)
        else $error("gate not high with enable");
    // long enough for a one-shot pulse from a short enable to end
    en_low_a: assert property (
        (!ENABLE_I)[*8] |-> !GATE_DRIVE_OUT_O) else $error("gate high");
    shot_len_a: assert property (
        $rose(GATE_DRIVE_OUT_O) && shot |-> ##SHOT_CYC !GATE_DRIVE_OUT_O)
        else $error("pulse length wrong");
    shot_rearm_a: assert property (
        (shot && ENABLE_I && !GATE_DRIVE_OUT_O)[*6] |=> !GATE_DRIVE_OUT_O)
        else $error("pulse without rearm");
    high_rail_a: assert property (
        (!SECONDARY_HIGH_RAIL_GOOD_I)[*4] |-> !GATE_DRIVE_OUT_O && KEEP_OFF_O)
        else $error("high rail fault ignored");
    mid_rail_a: assert property (
        (!SECONDARY_MID_RAIL_GOOD_I)[*4] |-> !GATE_DRIVE_OUT_O)
        else $error("mid rail fault ignored");
    thermal_off_a: assert property (
        THERMAL_FAULT_I[*4] |-> !GATE_DRIVE_OUT_O && !POWER_TRANSFER_O)
        else $error("thermal fault ignored");
    prim_timeout_a: assert property (
        low_cnt > TIMEOUT_CYC + 4 |-> !GATE_DRIVE_OUT_O)
        else $error("no timeout off");
    mode_hold_a: assert property (
        PRIMARY_SUPPLY_GOOD_I[*8] |=> $stable(THREE_WIRE_MODE_O))
        else $error("mode changed");
    cover property ($rose(GATE_DRIVE_OUT_O) && shot);
    cover property (low_cnt == TIMEOUT_CYC + 5);
    cover property (THERMAL_FAULT_I && ENABLE_I);
endmodule
bind igel_core igel_chk #(.TIMEOUT_CYC(TIMEOUT_CYC), .SHOT_CYC(SHOT_CYC))
    u_chk (.*);

/* tb/igel_host.sv */
// host model driving the enable pin
// assumes the bench sets req_i per request
`timescale 1ns/1ps
module igel_host (
    input wire logic clk_i,
    input wire logic req_i,
    output logic en_o
);
    // enable launched on the falling edge
    initial en_o = 1'b0;
    always @(negedge clk_i) begin
        en_o <= req_i;
    end
endmodule

/* tb/tb_isolated_gate_enable_logic.sv */
// self-checking bench for the gate enable logic
// assumes igel_core, its checker and the host model
`timescale 1ns/1ps
module tb_isolated_gate_enable_logic;
    logic CLK_I = 1'b0, RESET_I = 1'b1, req = 1'b0, en, prim = 1'b0;
    logic hi = 1'b1, mid = 1'b1, therm = 1'b0, strap = 1'b0, part = 1'b1;
    logic gate, keep, xfer, mode;
    int miscompares = 0, check_count = 0;
    igel_core #(.TIMEOUT_CYC(8), .SHOT_CYC(3)) u_dut (.CLK_I(CLK_I),
        .RESET_I(RESET_I), .ENABLE_I(en), .PRIMARY_SUPPLY_GOOD_I(prim),
        .SECONDARY_HIGH_RAIL_GOOD_I(hi), .SECONDARY_MID_RAIL_GOOD_I(mid),
        .THERMAL_FAULT_I(therm), .THREE_WIRE_STRAP_I(strap),
        .ONE_SHOT_VARIANT_I(part), .GATE_DRIVE_OUT_O(gate), .KEEP_OFF_O(keep),
        .POWER_TRANSFER_O(xfer), .THREE_WIRE_MODE_O(mode));
    igel_host u_host (.clk_i(CLK_I), .req_i(req), .en_o(en));
    task automatic cyc(input int n);
        repeat (n) @(negedge CLK_I);
    endtask
    task automatic chk(input logic got, input logic exp, input string m);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %0t %s", $time, m);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // level follow in two-wire mode with a one-shot part
    task automatic t_level();
        chk(mode, 1'b0, "mode");
        req <= 1'b1;
        cyc(8);
        chk(gate, 1'b1, "gate high");
        chk(xfer, 1'b1, "transfer on");
        req <= 1'b0;
        cyc(8);
        chk(gate, 1'b0, "gate low");
    endtask
    // each fault forces the gate low, then it recovers
    task automatic t_fault(input int k);
        req <= 1'b1;
        cyc(8);
        hi <= (k != 0);
        mid <= (k != 1);
        therm <= (k == 2);
        cyc(6);
        chk(gate, 1'b0, "fault gate");
        if (k == 0) chk(keep, 1'b1, "keep-off");
        if (k == 2) chk(xfer, 1'b0, "transfer");
        hi <= 1'b1;
        mid <= 1'b1;
        therm <= 1'b0;
        cyc(8);
        chk(gate, 1'b1, "recovered");
        chk(keep, 1'b0, "keep-off released");
        req <= 1'b0;
        cyc(4);
    endtask
    // primary loss: held until timeout, then off
    task automatic t_primary();
        req <= 1'b1;
        cyc(8);
        prim <= 1'b0;
        cyc(5);
        chk(gate, 1'b1, "held");
        cyc(10);
        chk(gate, 1'b0, "timeout off");
        req <= 1'b0;
    endtask
    // three-wire strap latched on primary rise, then held
    task automatic t_mode();
        strap <= 1'b1;
        cyc(4);
        prim <= 1'b1;
        cyc(8);
        strap <= 1'b0;
        cyc(4);
        chk(mode, 1'b1, "three-wire");
    endtask
    // one pulse per enable rise, rearmed by enable low
    task automatic t_shot();
        int n;
        repeat (2) begin
            n = 0;
            req <= 1'b1;
            repeat (16) begin
                cyc(1);
                if (gate === 1'b1) n++;
            end
            chk(n == 3, 1'b1, "pulse length");
            chk(gate, 1'b0, "low while held");
            req <= 1'b0;
            cyc(6);
        end
    endtask
    // three-wire part without one-shot after a primary cycle
    task automatic t_std3();
        prim <= 1'b0;
        strap <= 1'b1;
        part <= 1'b0;
        cyc(16);
        prim <= 1'b1;
        cyc(8);
        req <= 1'b1;
        cyc(8);
        chk(mode, 1'b1, "three-wire kept");
        chk(gate, 1'b1, "three-wire level");
        req <= 1'b0;
        cyc(4);
    endtask
    initial begin
        forever #12.5 CLK_I = ~CLK_I;
    end
    initial begin
        #50us;
        miscompares++;
        $display("mismatch %0t timeout", $time);
        summarize();
    end
    initial begin
        cyc(5);
        chk(gate, 1'b0, "reset gate");
        chk(keep, 1'b1, "reset keep-off");
        RESET_I <= 1'b0;
        prim <= 1'b1;
        cyc(8);
        t_level();
        for (int k = 0; k < 3; k++) t_fault(k);
        t_primary();
        t_mode();
        t_shot();
        t_std3();
        summarize();
    end
endmodule
